// ### rtl/wdsr_top.sv
// watchdog timer with system reset merge, reset pin and port reset states
// Function
// (RULE_01) counter starts at all ones, counts cycles
// (RULE_02) underflow sets first underflow flag
// (RULE_03) second underflow sets flag two, resets
// (RULE_04) watchdog reset pulls reset pin low
// (RULE_05) reset generation only while enable set
// (RULE_06) disable then refresh clears enable flag
// (RULE_07) lone disable leaves watchdog running
// (RULE_08) enable set by reset and backup entry
// (RULE_09) refresh with flag one clears, skips
// (RULE_10) refresh with flag zero, no skip
// (RULE_11) skip works while watchdog disabled
// (RULE_12) backup entry reinitialises flag and counter
// (RULE_13) software refreshes within 65534 cycles
// (RULE_14) any reset source causes system reset
// (RULE_15) after release, fetch address zero
// (RULE_16) external reset held one cycle minimum
// (RULE_17) software reset drives pin low, resets
// (RULE_18) reset: ports hi-z, pwm pin low
// (RULE_19) any other instruction cancels disable arm
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module wdsr_top
  import wdsr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic instr_valid,
  input wire logic refresh_instruction,
  input wire logic disable_instruction,
  input wire logic software_reset_instruction,
  input wire logic backup_entry,
  input wire logic power_on_reset,
  input wire logic voltage_drop_reset,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  output logic system_reset,
  output logic pc_to_zero,
  output logic skip_next,
  input wire logic [15:0] port_out_core,
  input wire logic [15:0] port_oe_core,
  input wire logic pwm_out_core,
  output logic [15:0] port_out,
  output logic [15:0] port_oe,
  output logic counter1_pwm_pin,
  output logic irq
);

  logic [15:0] watchdog_counter_r;
  logic watchdog_enable_flag_r;
  logic first_underflow_flag_r;
  logic second_underflow_flag_r;
  logic disarm_r;
  logic [3:0] hold_r;
  logic sys_rst_r;
  logic sys_rst_d_r;
  logic skip_r;
  logic [2:0] irq_st_r;
  logic [2:0] irq_msk_r;
  logic [31:0] prdata_r;

  logic refresh_ev;
  logic disable_ev;
  logic other_ev;
  logic underflow;
  logic wd_reset_req;
  logic int_reset_req;
  logic ext_reset_low;
  logic wr_en;
  logic rd_en;
  logic [2:0] irq_set;
  logic [2:0] irq_clr;
  logic software_reset_instruction_ev;
  logic any_src;
  logic addr_ok;
  logic [15:0] cnt_nxt;
  logic [3:0] hold_nxt;
  logic [31:0] stat_word;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic wdsr_hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  function automatic logic wdsr_mapped(input logic [7:0] a);
    return wdsr_hit(a, WDSR_A_CTRL) | wdsr_hit(a, WDSR_A_STAT) | wdsr_hit(a, WDSR_A_CNT) |
      wdsr_hit(a, WDSR_A_IRQ_ST) | wdsr_hit(a, WDSR_A_IRQ_MSK);
  endfunction

  function automatic logic [15:0] wdsr_dec16(input logic [15:0] v);
    return v - WDSR_CNT_ONE;
  endfunction

  function automatic logic [3:0] wdsr_dec4(input logic [3:0] v);
    return v - WDSR_HOLD_ONE;
  endfunction

  // widen a three bit field to a bus word
  function automatic logic [31:0] wdsr_word3(input logic [2:0] v);
    logic [31:0] w;
    w = WDSR_ZERO32;
    w[WDSR_IRQ_W-1:0] = v;
    return w;
  endfunction

  function automatic logic [31:0] wdsr_word16(input logic [15:0] v);
    logic [31:0] w;
    w = WDSR_ZERO32;
    w[WDSR_CNT_W-1:0] = v;
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // instruction strobes and reset merge
  always_comb begin
    refresh_ev = 1'b0;
    disable_ev = 1'b0;
    other_ev = 1'b0;
    if (instr_valid & ~system_reset) begin
      if (refresh_instruction) begin
        refresh_ev = 1'b1;
      end else if (disable_instruction) begin
        disable_ev = 1'b1;
      end else begin
        other_ev = 1'b1; // RULE_19
      end
    end
  end

  assign software_reset_instruction_ev = instr_valid & software_reset_instruction & ~system_reset;
  assign underflow = ~system_reset & (watchdog_counter_r == WDSR_CNT_ZERO); // RULE_02
  assign wd_reset_req = underflow & first_underflow_flag_r & watchdog_enable_flag_r; // RULE_03 RULE_05
  assign int_reset_req = wd_reset_req | software_reset_instruction_ev; // RULE_17
  assign cnt_nxt = wdsr_dec16(watchdog_counter_r);
  assign hold_nxt = wdsr_dec4(hold_r);

  // any one source is enough; the pin term keeps reset up while it is low
  always_comb begin
    any_src = 1'b0;
    if (ext_reset_low) begin
      any_src = 1'b1;
    end
    if (int_reset_req) begin
      any_src = 1'b1;
    end
    if (reset_pin_oe) begin
      any_src = 1'b1;
    end
    if (power_on_reset) begin
      any_src = 1'b1;
    end
    if (voltage_drop_reset) begin
      any_src = 1'b1;
    end
  end
  // pin level sampled directly; external agent holds it low a machine cycle
  assign ext_reset_low = ~reset_pin_in; // RULE_16
  assign system_reset = sys_rst_r; // RULE_14
  assign pc_to_zero = sys_rst_d_r & ~sys_rst_r; // RULE_15
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe = (hold_r != WDSR_HOLD_ZERO); // RULE_04 RULE_17
  assign skip_next = skip_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_r <= WDSR_HOLD_ZERO;
    end else if (int_reset_req) begin
      hold_r <= WDSR_RST_HOLD; // RULE_04
    end else if (hold_r != WDSR_HOLD_ZERO) begin
      hold_r <= hold_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_rst_r <= 1'b1;
    end else begin
      sys_rst_r <= any_src; // RULE_14
    end
  end

  // delayed copy marks the cycle in which reset has just ended
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_rst_d_r <= 1'b1;
    end else begin
      sys_rst_d_r <= sys_rst_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // watchdog counter and flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_counter_r <= WDSR_CNT_INIT;
    end else if (system_reset | backup_entry) begin
      watchdog_counter_r <= WDSR_CNT_INIT; // RULE_01 RULE_12
    end else begin
      watchdog_counter_r <= cnt_nxt; // RULE_01
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_enable_flag_r <= 1'b1;
    end else if (system_reset | backup_entry) begin
      watchdog_enable_flag_r <= 1'b1; // RULE_08
    end else if (refresh_ev & disarm_r) begin
      watchdog_enable_flag_r <= 1'b0; // RULE_06
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disarm_r <= 1'b0;
    end else if (system_reset) begin
      disarm_r <= 1'b0;
    end else if (disable_ev) begin
      disarm_r <= 1'b1; // RULE_19 RULE_07
    end else if (refresh_ev | other_ev) begin
      disarm_r <= 1'b0; // RULE_19
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_underflow_flag_r <= 1'b0;
    end else if (system_reset | backup_entry) begin
      first_underflow_flag_r <= 1'b0; // RULE_12
    end else if (underflow) begin
      first_underflow_flag_r <= 1'b1; // RULE_02
    end else if (refresh_ev) begin
      first_underflow_flag_r <= 1'b0; // RULE_09
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      second_underflow_flag_r <= 1'b0;
    end else if (wd_reset_req) begin
      second_underflow_flag_r <= 1'b1; // RULE_03
    end else if (system_reset) begin
      second_underflow_flag_r <= 1'b0;
    end
  end

  // skip does not look at the enable flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      skip_r <= 1'b0;
    end else begin
      skip_r <= refresh_ev & first_underflow_flag_r; // RULE_09 RULE_10 RULE_11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // port states during reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_out <= WDSR_PORT_ZERO;
    end else if (system_reset) begin
      port_out <= WDSR_PORT_ZERO;
    end else begin
      port_out <= port_out_core;
    end
  end

  // drivers off gives high impedance on the general ports
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_oe <= WDSR_PORT_ZERO;
    end else if (system_reset) begin
      port_oe <= WDSR_PORT_ZERO; // RULE_18
    end else begin
      port_oe <= port_oe_core;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter1_pwm_pin <= 1'b0;
    end else if (system_reset) begin
      counter1_pwm_pin <= 1'b0; // RULE_18
    end else begin
      counter1_pwm_pin <= pwm_out_core;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts
  assign irq_set = {skip_r, wd_reset_req, underflow};
  assign irq = |(irq_st_r & irq_msk_r);

  always_comb begin
    irq_clr = WDSR_IRQ_ZERO;
    if (wr_en & wdsr_hit(paddr, WDSR_A_IRQ_ST)) begin
      irq_clr = pwdata[WDSR_IRQ_W-1:0];
    end
  end

  // a new event in the clearing cycle survives the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st_r <= WDSR_IRQ_ZERO;
    end else begin
      irq_st_r <= (irq_st_r & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_msk_r <= WDSR_IRQ_ZERO;
    end else if (wr_en & wdsr_hit(paddr, WDSR_A_IRQ_MSK)) begin
      irq_msk_r <= pwdata[WDSR_IRQ_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;
  assign prdata = prdata_r;
  assign addr_ok = wdsr_mapped(paddr);
  assign pslverr = psel & penable & ~addr_ok;

  always_comb begin
    stat_word = WDSR_ZERO32;
    stat_word[WDSR_B_EN] = watchdog_enable_flag_r;
    stat_word[WDSR_B_F1] = first_underflow_flag_r;
    stat_word[WDSR_B_F2] = second_underflow_flag_r;
    stat_word[WDSR_B_ARM] = disarm_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= WDSR_ZERO32;
    end else if (rd_en) begin
      unique case (1'b1)
        wdsr_hit(paddr, WDSR_A_STAT): begin
          prdata_r <= stat_word;
        end
        wdsr_hit(paddr, WDSR_A_CNT): begin
          prdata_r <= wdsr_word16(watchdog_counter_r);
        end
        wdsr_hit(paddr, WDSR_A_IRQ_ST): begin
          prdata_r <= wdsr_word3(irq_st_r);
        end
        wdsr_hit(paddr, WDSR_A_IRQ_MSK): begin
          prdata_r <= wdsr_word3(irq_msk_r);
        end
        default: begin
          prdata_r <= WDSR_ZERO32;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ### rtl/wdsr_pkg.sv
// package: constants and register map for the watchdog and system reset block
package wdsr_pkg;
  localparam int unsigned WDSR_CNT_W = 16;
  localparam logic [15:0] WDSR_CNT_INIT = 16'hffff;
  localparam logic [15:0] WDSR_CNT_ZERO = 16'h0000;
  localparam logic [15:0] WDSR_CNT_ONE = 16'h0001;
  // machine cycle of the core, in ns, and least external reset low time
  localparam int unsigned WDSR_CLK_PERIOD_NS = 100;
  localparam int unsigned WDSR_EXT_RST_MIN_NS = 100;
  localparam int unsigned WDSR_EXT_RST_CYC = (WDSR_EXT_RST_MIN_NS + WDSR_CLK_PERIOD_NS - 1) / WDSR_CLK_PERIOD_NS;
  // cycles the reset pin is driven low after an internal reset request
  localparam logic [3:0] WDSR_RST_HOLD = 4'h4;
  localparam logic [3:0] WDSR_HOLD_ZERO = 4'h0;
  localparam logic [3:0] WDSR_HOLD_ONE = 4'h1;
  localparam int unsigned WDSR_PORT_W = 16;
  localparam logic [15:0] WDSR_PORT_ZERO = 16'h0000;
  localparam logic [15:0] WDSR_PORT_ONES = 16'hffff;
  // apb register map, byte addresses
  localparam logic [7:0] WDSR_A_CTRL = 8'h00;
  localparam logic [7:0] WDSR_A_STAT = 8'h04;
  localparam logic [7:0] WDSR_A_CNT = 8'h08;
  localparam logic [7:0] WDSR_A_IRQ_ST = 8'h0c;
  localparam logic [7:0] WDSR_A_IRQ_MSK = 8'h10;
  // status bit positions
  localparam int unsigned WDSR_B_EN = 0;
  localparam int unsigned WDSR_B_F1 = 1;
  localparam int unsigned WDSR_B_F2 = 2;
  localparam int unsigned WDSR_B_ARM = 3;
  // interrupt bit positions
  localparam int unsigned WDSR_I_UF1 = 0;
  localparam int unsigned WDSR_I_REFRESH_INSTRUCTION = 1;
  localparam int unsigned WDSR_I_SKIP = 2;
  localparam int unsigned WDSR_IRQ_W = 3;
  localparam logic [2:0] WDSR_IRQ_ZERO = 3'h0;
  localparam logic [31:0] WDSR_ZERO32 = 32'h0000_0000;
endpackage

// ### tb/wdsr_properties.sv
// checker: reset pin, reset merge, port and skip relations
`timescale 1ns/1ns
`default_nettype none
module wdsr_properties
  import wdsr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic instr_valid,
  input wire logic refresh_instruction,
  input wire logic software_reset_instruction,
  input wire logic power_on_reset,
  input wire logic voltage_drop_reset,
  input wire logic reset_pin_in,
  input wire logic reset_pin_oe,
  input wire logic system_reset,
  input wire logic pc_to_zero,
  input wire logic skip_next,
  input wire logic [15:0] port_oe,
  input wire logic counter1_pwm_pin
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence pin_low_s;
    reset_pin_oe [*4] ##1 !reset_pin_oe;
  endsequence
  pin_hold_a: assert property ($rose(reset_pin_oe) |-> pin_low_s) else $error("pin hold");
  pin_reset_a: assert property (reset_pin_oe |-> system_reset) else $error("pin no reset");
  software_reset_instruction_pin_a: assert property (instr_valid && software_reset_instruction && !system_reset |=> reset_pin_oe)
    else $error("software_reset_instruction pin");
  src_merge_a: assert property (!reset_pin_in || power_on_reset || voltage_drop_reset |=> system_reset)
    else $error("source lost");
  port_hiz_a: assert property (system_reset && $past(system_reset) |-> port_oe == WDSR_PORT_ZERO && !counter1_pwm_pin)
    else $error("port drive");
  start_zero_a: assert property ($fell(system_reset) |-> ##[0:1] pc_to_zero) else $error("no start");
  pc_pulse_a: assert property (pc_to_zero |=> !pc_to_zero) else $error("pc pulse");
  skip_cause_a: assert property (skip_next |-> $past(instr_valid) && $past(refresh_instruction))
    else $error("stray skip");
endmodule
bind wdsr_top wdsr_properties u_props (.pclk, .presetn, .instr_valid, .refresh_instruction,
  .software_reset_instruction, .power_on_reset, .voltage_drop_reset, .reset_pin_in, .reset_pin_oe,
  .system_reset, .pc_to_zero, .skip_next, .port_oe, .counter1_pwm_pin);
`default_nettype wire

// ### tb/wdsr_core_model.sv
// core model: issues one watchdog instruction at a time
`timescale 1ns/1ns
`default_nettype none
module wdsr_core_model (
  input wire logic pclk,
  input wire logic system_reset,
  output logic instr_valid,
  output logic refresh_instruction,
  output logic disable_instruction,
  output logic software_reset_instruction
);
  initial begin
    instr_valid = 1'b0;
    refresh_instruction = 1'b0;
    disable_instruction = 1'b0;
    software_reset_instruction = 1'b0;
  end
  // kind: 0 other, 1 refresh, 2 disable, 3 software reset
  task automatic issue(input logic [1:0] k);
    while (system_reset !== 1'b0) @(posedge pclk);
    instr_valid <= 1'b1;
    refresh_instruction <= (k == 2'h1);
    disable_instruction <= (k == 2'h2);
    software_reset_instruction <= (k == 2'h3);
    @(posedge pclk);
    instr_valid <= 1'b0;
    // qualifiers are meaningless now, so scramble them
    refresh_instruction <= ~refresh_instruction;
    disable_instruction <= ~disable_instruction;
    software_reset_instruction <= ~software_reset_instruction;
    repeat (2) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// ### tb/wdsr_top_tb.sv
// testbench: watchdog, reset merge and port reset checks
`timescale 1ns/1ns
`default_nettype none
module wdsr_top_tb;
  import wdsr_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, lfsr = 32'h9c169620;
  logic pready, pslverr, serr, instr_valid, refresh_instruction, disable_instruction, software_reset_instruction;
  logic backup_entry = 1'b0, power_on_reset = 1'b0, voltage_drop_reset = 1'b0, ext_n = 1'b1;
  logic reset_pin_in, reset_pin_out, reset_pin_oe, system_reset, pc_to_zero, skip_next, irq, oe_d;
  logic [15:0] port_out_core, port_oe_core, oe_prev, port_out, port_oe;
  logic pwm_out_core, counter1_pwm_pin;
  logic [31:0] exp_q[$], got_q[$];
  int n_fail = 0, cmp_count = 0, n_pc = 0, n_skip = 0, n_oe = 0;
  assign reset_pin_in = reset_pin_oe ? reset_pin_out : ext_n;
  wdsr_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .instr_valid, .refresh_instruction, .disable_instruction, .software_reset_instruction, .backup_entry,
    .power_on_reset, .voltage_drop_reset, .reset_pin_in, .reset_pin_out, .reset_pin_oe, .system_reset,
    .pc_to_zero, .skip_next, .port_out_core, .port_oe_core, .pwm_out_core, .port_out, .port_oe,
    .counter1_pwm_pin, .irq);
  wdsr_core_model core (.pclk, .system_reset, .instr_valid, .refresh_instruction, .disable_instruction,
    .software_reset_instruction);
  always #50 pclk = ~pclk;
  function automatic logic [31:0] step(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  always @(posedge pclk) begin
    lfsr <= step(lfsr);
    {port_oe_core, port_out_core} <= lfsr;
    pwm_out_core <= lfsr[3];
    oe_prev <= port_oe_core;
    oe_d <= reset_pin_oe;
    n_pc <= n_pc + (pc_to_zero === 1'b1);
    n_skip <= n_skip + (skip_next === 1'b1);
    n_oe <= n_oe + (reset_pin_oe === 1'b1 && oe_d !== 1'b1);
  end
  ////////////////////////////////////////////////////////////////
  always @(negedge pclk) while (got_q.size() > 0) begin
    cmp_count++;
    if (got_q[0] !== exp_q[0]) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got_q[0], exp_q[0]);
    end
    void'(got_q.pop_front());
    void'(exp_q.pop_front());
  end
  task automatic note(input logic [31:0] e, input logic [31:0] g);
    exp_q.push_back(e);
    got_q.push_back(g);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    note(e, r);
  endtask
  task automatic wait_rel();
    for (int i = 0; i < 50 && system_reset !== 1'b0; i++) @(posedge pclk);
    repeat (3) @(posedge pclk);
  endtask
  task automatic give_verdict();
    repeat (2) @(negedge pclk);
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #(90000 * WDSR_CLK_PERIOD_NS);
    n_fail++;
    give_verdict();
  end
  ////////////////////////////////////////////////////////////////
  initial begin : main
    logic [31:0] r;
    repeat (4) @(posedge pclk);
    note(port_oe, 32'h0);
    note(counter1_pwm_pin, 32'h0);
    presetn <= 1'b1;
    wait_rel();
    rd(WDSR_A_STAT, 32'h1);
    rd(8'h20, 32'h0);
    note(serr, 32'h1);
    core.issue(2'h2);
    rd(WDSR_A_STAT, 32'h9);
    core.issue(2'h0);
    core.issue(2'h1);
    rd(WDSR_A_STAT, 32'h1);
    note(n_skip, 32'h0);
    $display("test instructions done");
    for (int k = 0; k < 4; k++) begin
      if (k == 3)
        core.issue(2'h3);
      else begin
        ext_n <= (k != 0);
        power_on_reset <= (k == 1);
        voltage_drop_reset <= (k == 2);
        @(posedge pclk);
        {ext_n, power_on_reset, voltage_drop_reset} <= 3'h4;
      end
      wait_rel();
      note(n_pc, k + 2);
    end
    note(n_oe, 32'h1);
    note(port_oe, oe_prev);
    $display("test reset sources done");
    r = 32'h0;
    for (int i = 0; i < 24000 && r[WDSR_B_F1] !== 1'b1; i++) apb(1'b0, WDSR_A_STAT, 32'h0, r);
    note(r, 32'h3);
    note(irq, 32'h0);
    apb(1'b1, WDSR_A_IRQ_MSK, 32'h1, r);
    note(irq, 32'h1);
    core.issue(2'h1);
    note(n_skip, 32'h1);
    rd(WDSR_A_STAT, 32'h1);
    apb(1'b1, WDSR_A_IRQ_ST, 32'h5, r);
    note(irq, 32'h0);
    rd(WDSR_A_IRQ_ST, 32'h0);
    $display("test underflow done");
    core.issue(2'h2);
    core.issue(2'h1);
    rd(WDSR_A_STAT, 32'h0);
    backup_entry <= 1'b1;
    @(posedge pclk);
    backup_entry <= 1'b0;
    rd(WDSR_A_STAT, 32'h1);
    apb(1'b0, WDSR_A_CNT, 32'h0, r);
    note(r > 32'hfff0, 32'h1);
    $display("test disable and backup done");
    give_verdict();
  end
endmodule
`default_nettype wire
